// file: inc/irq_warn_pkg.sv
// constants for the status, enable and limit registers of the event block
// shared by the event block and its direction-change detector
package irq_warn_pkg;
    // register port geometry, phase and energy channel counts
    localparam int          ADDR_W              = 10;
    localparam int          DATA_W              = 16;
    localparam int          PHASES              = 3;
    localparam int          ENERGY_CH           = 8;
    // register offsets
    localparam logic [9:0]  STATUS_PRIMARY_ADDR   = 10'h001;
    localparam logic [9:0]  STATUS_SECONDARY_ADDR = 10'h002;
    localparam logic [9:0]  ENABLE_PRIMARY_ADDR   = 10'h003;
    localparam logic [9:0]  ENABLE_SECONDARY_ADDR = 10'h004;
    localparam logic [9:0]  COMPUTED_LIMIT_ADDR   = 10'h00A;
    localparam logic [9:0]  SAMPLED_LIMIT_ADDR    = 10'h00B;
    localparam logic [9:0]  VDIST_LIMIT_ADDR      = 10'h00C;
    localparam logic [9:0]  IDIST_LIMIT_ADDR      = 10'h00D;
    // reset values
    localparam logic [15:0] STATUS_RESET        = 16'h0000;
    localparam logic [15:0] ENABLE_RESET        = 16'h0000;
    localparam logic [15:0] NEUTRAL_LIMIT_RESET = 16'hFFFF;
    localparam logic [15:0] DIST_LIMIT_RESET    = 16'h0000;
    // primary status field positions
    localparam int          CSUM_FIRST_BIT      = 14;
    localparam int          CSUM_SECOND_BIT     = 12;
    localparam int          CSUM_THIRD_BIT      = 10;
    localparam int          CSUM_FOURTH_BIT     = 8;
    localparam int          VSEQ_BIT            = 7;
    localparam int          ISEQ_BIT            = 6;
    localparam int          DIP_BIT             = 3;
    localparam int          LOSS_BIT            = 2;
    // secondary status field positions
    localparam int          SAMPLED_OVER_BIT    = 15;
    localparam int          COMPUTED_OVER_BIT   = 14;
    localparam int          VDIST_OVER_BIT      = 11;
    localparam int          IDIST_OVER_BIT      = 10;
    localparam int          HARMONIC_READY_BIT  = 9;
    localparam int          REACTIVE_LSB        = 4;
    localparam int          ACTIVE_LSB          = 0;
    // implemented bits of the status and enable registers; checksum and reversal bit groups
    localparam logic [15:0] STATUS_PRIMARY_MASK   = 16'h55CC;
    localparam logic [15:0] ENABLE_PRIMARY_MASK   = 16'h04CC;
    localparam logic [15:0] SECONDARY_MASK        = 16'hCEFF;
    localparam logic [15:0] CHECKSUM_MASK         = 16'h5500;
    localparam logic [7:0]  REVERSAL_MASK         = 8'hFF;
endpackage

// file: verilog/energy_reversal_detect.sv
// one energy channel: flags a change of direction of its accumulator
// step_i pulses each time the accumulator moves one unit of the chosen resolution
`timescale 1ns/1ns
`default_nettype none
module energy_reversal_detect
    import irq_warn_pkg::*;
(
    // clock and reset
    input  wire logic clock_i,
    input  wire logic arst_n_i,
    // accumulator side
    input  wire logic step_i,
    input  wire logic reverse_i,
    // event
    output logic      change_o
);
    logic dir_r;
    logic dir_nxt;
    logic seen_r;
    logic seen_nxt;

    // first step only learns the direction
    assign dir_nxt  = step_i ? reverse_i : dir_r;
    assign seen_nxt = seen_r | step_i;
    assign change_o = step_i & seen_r & (reverse_i != dir_r);

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            dir_r  <= 1'b0;
            seen_r <= 1'b0;
        end else begin
            dir_r  <= dir_nxt;
            seen_r <= seen_nxt;
        end
    end

    a_reversal_pulse: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        (step_i && seen_r && reverse_i != dir_r) |-> change_o)
        else $error("reversal not flagged");
endmodule
`default_nettype wire

// file: verilog/metering_irq_warn_status.sv
// event status, interrupt enables and interrupt/warning pins of the meter
// register port comes from the serial front end on the same clock;
// event inputs come from the detectors on the same clock
`timescale 1ns/1ns
`default_nettype none
module metering_irq_warn_status
    import irq_warn_pkg::*;
#(
    parameter int NUM_PHASES = PHASES
)
(
    // clock and reset
    input  wire logic                     clock_i,
    input  wire logic                     arst_n_i,
    // register port
    input  wire logic [ADDR_W-1:0]        reg_addr_i,
    input  wire logic                     reg_wr_i,
    input  wire logic                     reg_rd_i,
    input  wire logic [DATA_W-1:0]        reg_wdata_i,
    output logic      [DATA_W-1:0]        reg_rdata_o,
    // checksum and phase detectors
    input  wire logic [3:0]               checksum_error_i,
    input  wire logic                     voltage_sequence_fault_i,
    input  wire logic                     current_sequence_fault_i,
    input  wire logic                     voltage_dip_i,
    input  wire logic                     phase_loss_i,
    // neutral and distortion measurements
    input  wire logic [15:0]              sampled_neutral_rms_i,
    input  wire logic [15:0]              computed_neutral_rms_i,
    input  wire logic [NUM_PHASES-1:0][15:0] voltage_distortion_i,
    input  wire logic [NUM_PHASES-1:0][15:0] current_distortion_i,
    input  wire logic                     harmonic_results_ready_i,
    // energy accumulators
    input  wire logic                     energy_resolution_select_i,
    input  wire logic [ENERGY_CH-1:0]     energy_step_fine_i,
    input  wire logic [ENERGY_CH-1:0]     energy_step_coarse_i,
    input  wire logic [ENERGY_CH-1:0]     energy_reverse_i,
    // pins
    output logic                          interrupt_pin_first_o,
    output logic                          interrupt_pin_second_o,
    output logic                          warning_output_pin_o
);
    if (NUM_PHASES < 1 || NUM_PHASES > 8) begin : g_phase_check
        $error("NUM_PHASES out of range");
    end

    // registers
    logic [15:0] status_primary_r;
    logic [15:0] status_primary_nxt;
    logic [15:0] status_secondary_r;
    logic [15:0] status_secondary_nxt;
    logic [15:0] enable_primary_r;
    logic [15:0] enable_primary_nxt;
    logic [15:0] enable_secondary_r;
    logic [15:0] enable_secondary_nxt;
    logic [15:0] computed_limit_r;
    logic [15:0] computed_limit_nxt;
    logic [15:0] sampled_limit_r;
    logic [15:0] sampled_limit_nxt;
    logic [15:0] vdist_limit_r;
    logic [15:0] vdist_limit_nxt;
    logic [15:0] idist_limit_r;
    logic [15:0] idist_limit_nxt;
    logic [15:0] rdata_r;
    logic [15:0] rdata_nxt;
    logic        irq_first_r;
    logic        irq_first_nxt;
    logic        irq_second_r;
    logic        irq_second_nxt;
    logic        warn_r;
    logic        warn_nxt;

    // address decode
    wire sel_status_primary   = (reg_addr_i == STATUS_PRIMARY_ADDR);
    wire sel_status_secondary = (reg_addr_i == STATUS_SECONDARY_ADDR);
    wire sel_enable_primary   = (reg_addr_i == ENABLE_PRIMARY_ADDR);
    wire sel_enable_secondary = (reg_addr_i == ENABLE_SECONDARY_ADDR);
    wire sel_computed_limit   = (reg_addr_i == COMPUTED_LIMIT_ADDR);
    wire sel_sampled_limit    = (reg_addr_i == SAMPLED_LIMIT_ADDR);
    wire sel_vdist_limit      = (reg_addr_i == VDIST_LIMIT_ADDR);
    wire sel_idist_limit      = (reg_addr_i == IDIST_LIMIT_ADDR);

    wire clear_primary   = reg_rd_i & sel_status_primary;
    wire clear_secondary = reg_rd_i & sel_status_secondary;

    // threshold comparisons
    logic vdist_over;
    logic idist_over;
    always_comb begin
        vdist_over = 1'b0;
        idist_over = 1'b0;
        for (int p = 0; p < NUM_PHASES; p++) begin
            if (voltage_distortion_i[p] > vdist_limit_r) begin
                vdist_over = 1'b1;
            end
            if (current_distortion_i[p] > idist_limit_r) begin
                idist_over = 1'b1;
            end
        end
    end

    wire sampled_over  = sampled_neutral_rms_i > sampled_limit_r;
    wire computed_over = computed_neutral_rms_i > computed_limit_r;

    // direction change per energy channel
    wire [ENERGY_CH-1:0] energy_step = energy_resolution_select_i ?
                                       energy_step_fine_i : energy_step_coarse_i;
    wire [ENERGY_CH-1:0] reversal;

    genvar ch;
    generate
        for (ch = 0; ch < ENERGY_CH; ch++) begin : g_rev
            energy_reversal_detect u_rev (
                .clock_i   (clock_i),
                .arst_n_i  (arst_n_i),
                .step_i    (energy_step[ch]),
                .reverse_i (energy_reverse_i[ch]),
                .change_o  (reversal[ch])
            );
        end
    endgenerate

    // event set vectors
    logic [15:0] set_primary;
    logic [15:0] set_secondary;
    always_comb begin
        set_primary                     = 16'h0000;
        set_primary[CSUM_FIRST_BIT]     = checksum_error_i[0];
        set_primary[CSUM_SECOND_BIT]    = checksum_error_i[1];
        set_primary[CSUM_THIRD_BIT]     = checksum_error_i[2];
        set_primary[CSUM_FOURTH_BIT]    = checksum_error_i[3];
        set_primary[VSEQ_BIT]           = voltage_sequence_fault_i;
        set_primary[ISEQ_BIT]           = current_sequence_fault_i;
        set_primary[DIP_BIT]            = voltage_dip_i;
        set_primary[LOSS_BIT]           = phase_loss_i;
        set_secondary                   = 16'h0000;
        set_secondary[SAMPLED_OVER_BIT] = sampled_over;
        set_secondary[COMPUTED_OVER_BIT] = computed_over;
        set_secondary[VDIST_OVER_BIT]   = vdist_over;
        set_secondary[IDIST_OVER_BIT]   = idist_over;
        set_secondary[HARMONIC_READY_BIT] = harmonic_results_ready_i;
        set_secondary[REACTIVE_LSB+3:REACTIVE_LSB] = reversal[7:4];
        set_secondary[ACTIVE_LSB+3:ACTIVE_LSB]     = reversal[3:0];
    end

    // read clears only what was read; a new event in that cycle survives
    assign status_primary_nxt =
        ((clear_primary ? 16'h0000 : status_primary_r) | set_primary)
        & STATUS_PRIMARY_MASK;
    assign status_secondary_nxt =
        ((clear_secondary ? 16'h0000 : status_secondary_r) | set_secondary)
        & SECONDARY_MASK;

    // writable registers, reserved bits held zero
    assign enable_primary_nxt = (reg_wr_i && sel_enable_primary) ?
                                (reg_wdata_i & ENABLE_PRIMARY_MASK) : enable_primary_r;
    assign enable_secondary_nxt = (reg_wr_i && sel_enable_secondary) ?
                                  (reg_wdata_i & SECONDARY_MASK) : enable_secondary_r;
    assign computed_limit_nxt = (reg_wr_i && sel_computed_limit) ?
                                reg_wdata_i : computed_limit_r;
    assign sampled_limit_nxt  = (reg_wr_i && sel_sampled_limit) ?
                                reg_wdata_i : sampled_limit_r;
    assign vdist_limit_nxt    = (reg_wr_i && sel_vdist_limit) ?
                                reg_wdata_i : vdist_limit_r;
    assign idist_limit_nxt    = (reg_wr_i && sel_idist_limit) ?
                                reg_wdata_i : idist_limit_r;

    // read data; unmapped offsets read zero
    wire [15:0] read_value =
        sel_status_primary   ? status_primary_r   :
        sel_status_secondary ? status_secondary_r :
        sel_enable_primary   ? enable_primary_r   :
        sel_enable_secondary ? enable_secondary_r :
        sel_computed_limit   ? computed_limit_r   :
        sel_sampled_limit    ? sampled_limit_r    :
        sel_vdist_limit      ? vdist_limit_r      :
        sel_idist_limit      ? idist_limit_r      : 16'h0000;
    assign rdata_nxt = reg_rd_i ? read_value : rdata_r;

    // pins follow the flags in the same cycle they set
    assign irq_first_nxt  = |(status_primary_nxt & enable_primary_nxt);
    assign irq_second_nxt = |(status_secondary_nxt & enable_secondary_nxt);
    assign warn_nxt       = |(status_primary_nxt & CHECKSUM_MASK);

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            status_primary_r   <= STATUS_RESET;
            status_secondary_r <= STATUS_RESET;
            enable_primary_r   <= ENABLE_RESET;
            enable_secondary_r <= ENABLE_RESET;
        end else begin
            status_primary_r   <= status_primary_nxt;
            status_secondary_r <= status_secondary_nxt;
            enable_primary_r   <= enable_primary_nxt;
            enable_secondary_r <= enable_secondary_nxt;
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            computed_limit_r <= NEUTRAL_LIMIT_RESET;
            sampled_limit_r  <= NEUTRAL_LIMIT_RESET;
            vdist_limit_r    <= DIST_LIMIT_RESET;
            idist_limit_r    <= DIST_LIMIT_RESET;
        end else begin
            computed_limit_r <= computed_limit_nxt;
            sampled_limit_r  <= sampled_limit_nxt;
            vdist_limit_r    <= vdist_limit_nxt;
            idist_limit_r    <= idist_limit_nxt;
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdata_r      <= 16'h0000;
            irq_first_r  <= 1'b0;
            irq_second_r <= 1'b0;
            warn_r       <= 1'b0;
        end else begin
            rdata_r      <= rdata_nxt;
            irq_first_r  <= irq_first_nxt;
            irq_second_r <= irq_second_nxt;
            warn_r       <= warn_nxt;
        end
    end

    assign reg_rdata_o            = rdata_r;
    assign interrupt_pin_first_o  = irq_first_r;
    assign interrupt_pin_second_o = irq_second_r;
    assign warning_output_pin_o   = warn_r;

    // checks
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!arst_n_i);

    a_first_pin_level: assert property (
        interrupt_pin_first_o == |(status_primary_r & enable_primary_r))
        else $error("first interrupt pin disagrees with enabled flags");

    a_second_pin_level: assert property (
        interrupt_pin_second_o == |(status_secondary_r & enable_secondary_r))
        else $error("second interrupt pin disagrees with enabled flags");

    a_read_clears_flags: assert property (
        clear_primary |=> (status_primary_r & ~$past(set_primary)) == 16'h0000)
        else $error("primary status not cleared by read");

    a_read_returns_flags: assert property (
        clear_secondary |=> reg_rdata_o == $past(status_secondary_r))
        else $error("secondary status read wrong value");

    a_warn_on_checksum: assert property (
        checksum_error_i != 4'h0 |=> warning_output_pin_o
            && (status_primary_r & CHECKSUM_MASK) != 16'h0000)
        else $error("warning pin not raised on checksum error");

    a_set_wins_clear: assert property (
        (phase_loss_i && clear_primary) |=> status_primary_r[LOSS_BIT])
        else $error("phase loss lost against clearing read");

    a_dip_sets_flag: assert property (
        voltage_dip_i |=> status_primary_r[DIP_BIT] ##1 status_primary_r[DIP_BIT]
            || $past(clear_primary))
        else $error("voltage dip flag not set");

    a_neutral_strict: assert property (
        (!clear_secondary && sampled_neutral_rms_i == sampled_limit_r
            && !$past(sampled_over) && !status_secondary_r[SAMPLED_OVER_BIT])
        |=> !status_secondary_r[SAMPLED_OVER_BIT])
        else $error("sampled neutral flag set at equal value");

    a_neutral_over: assert property (
        sampled_over |=> status_secondary_r[SAMPLED_OVER_BIT])
        else $error("sampled neutral over limit not flagged");

    a_enable_write: assert property (
        (reg_wr_i && sel_enable_secondary) |=>
            enable_secondary_r == ($past(reg_wdata_i) & SECONDARY_MASK))
        else $error("secondary enable write not taken");

    a_enable_readback: assert property (
        (reg_rd_i && sel_enable_primary) |=> reg_rdata_o == $past(enable_primary_r)
            && (reg_rdata_o & ~ENABLE_PRIMARY_MASK) == 16'h0000)
        else $error("primary enable read back wrong");

    a_pin_drops: assert property (
        (clear_primary && (set_primary & enable_primary_r) == 16'h0000
            && !(reg_wr_i && sel_enable_primary)) |=> !interrupt_pin_first_o)
        else $error("first interrupt pin stuck after clearing read");

    c_first_irq: cover property (
        $rose(interrupt_pin_first_o) ##[1:20] $fell(interrupt_pin_first_o));
    c_second_irq: cover property ($rose(interrupt_pin_second_o));
    c_warn_rise: cover property ($rose(warning_output_pin_o));
    c_reversal: cover property (reversal != 8'h00);
endmodule
`default_nettype wire

// file: test/host_model.sv
// host side of the register port: one-cycle read and write strobes
// assumes the block samples the strobes on the rising edge of clock_i
`timescale 1ns/1ns
`default_nettype none
module host_model
    import irq_warn_pkg::*;
(
    // clock
    input  wire logic              clock_i,
    // register port
    input  wire logic [DATA_W-1:0] reg_rdata_i,
    output logic      [ADDR_W-1:0] reg_addr_o,
    output logic                   reg_wr_o,
    output logic                   reg_rd_o,
    output logic      [DATA_W-1:0] reg_wdata_o
);
    initial begin
        reg_addr_o  = 10'h000;
        reg_wr_o    = 1'b0;
        reg_rd_o    = 1'b0;
        reg_wdata_o = 16'h0000;
    end

    task automatic write_reg(input logic [9:0] addr, input logic [15:0] data,
                             input logic [15:0] keep);
        @(posedge clock_i);
        reg_addr_o  <= addr;
        reg_wdata_o <= data & keep;
        reg_wr_o    <= 1'b1;
        @(posedge clock_i);
        reg_wr_o    <= 1'b0;
        // released lines must not keep their old value
        reg_addr_o  <= ~addr;
        reg_wdata_o <= ~(data & keep);
    endtask

    task automatic read_reg(input logic [9:0] addr, output logic [15:0] data);
        @(posedge clock_i);
        reg_addr_o <= addr;
        reg_rd_o   <= 1'b1;
        @(posedge clock_i);
        reg_rd_o   <= 1'b0;
        reg_addr_o <= ~addr;
        #1;
        data = reg_rdata_i;
    endtask
endmodule
`default_nettype wire

// file: test/tb.sv
// bench for the event status block: host model on the register port,
// bench drives every event input from the same clock
`timescale 1ns/1ns
`default_nettype none
module tb
    import irq_warn_pkg::*;
;
    logic                   clock_i = 1'b0;
    logic                   arst_n_i = 1'b0;
    logic [ADDR_W-1:0]      addr;
    logic                   wr;
    logic                   rd;
    logic [DATA_W-1:0]      wdata;
    logic [DATA_W-1:0]      rdata;
    logic [3:0]             cs_err = 4'h0;
    logic                   vseq = 1'b0;
    logic                   iseq = 1'b0;
    logic                   dip = 1'b0;
    logic                   loss = 1'b0;
    logic [15:0]            srms = 16'h0000;
    logic [15:0]            crms = 16'h0000;
    logic [2:0][15:0]       vdist = '0;
    logic [2:0][15:0]       idist = '0;
    logic                   hready = 1'b0;
    logic                   rsel = 1'b0;
    logic [7:0]             sfine = 8'h00;
    logic [7:0]             scoarse = 8'h00;
    logic [7:0]             srev = 8'h00;
    logic                   pin1;
    logic                   pin2;
    logic                   warn;
    integer                 seed = 32'hA586;
    int                     failures = 0;
    int                     checks_done = 0;
    int                     ph = 0;
    logic [15:0]            en;
    logic [15:0]            lim;
    int                     pbit [8] = '{14, 12, 10, 8, 7, 6, 3, 2};
    int                     sbit [5] = '{15, 14, 11, 10, 9};
    logic [9:0]             larr [4] = '{10'h00B, 10'h00A, 10'h00C, 10'h00D};
    logic [9:0]             raddr [9] = '{10'h001, 10'h002, 10'h003, 10'h004, 10'h00A,
                                          10'h00B, 10'h00C, 10'h00D, 10'h3FF};
    logic [15:0]            rrst [9] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'hFFFF,
                                         16'hFFFF, 16'h0000, 16'h0000, 16'h0000};

    always #50 clock_i = ~clock_i;

    host_model host (.clock_i(clock_i), .reg_rdata_i(rdata), .reg_addr_o(addr),
                     .reg_wr_o(wr), .reg_rd_o(rd), .reg_wdata_o(wdata));

    metering_irq_warn_status dut (
        .clock_i(clock_i), .arst_n_i(arst_n_i), .reg_addr_i(addr), .reg_wr_i(wr),
        .reg_rd_i(rd), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
        .checksum_error_i(cs_err), .voltage_sequence_fault_i(vseq),
        .current_sequence_fault_i(iseq), .voltage_dip_i(dip), .phase_loss_i(loss),
        .sampled_neutral_rms_i(srms), .computed_neutral_rms_i(crms),
        .voltage_distortion_i(vdist), .current_distortion_i(idist),
        .harmonic_results_ready_i(hready), .energy_resolution_select_i(rsel),
        .energy_step_fine_i(sfine), .energy_step_coarse_i(scoarse),
        .energy_reverse_i(srev), .interrupt_pin_first_o(pin1),
        .interrupt_pin_second_o(pin2), .warning_output_pin_o(warn));

    function automatic logic [15:0] onehot(input int b);
        return 16'h0001 << b;
    endfunction

    task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: word %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_pin(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: pin %b expected %b", $time, got, exp);
        end
    endtask

    task automatic print_verdict;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic tick;
        @(posedge clock_i);
        #1;
    endtask

    task automatic rd_check(input logic [9:0] a, input logic [15:0] exp);
        logic [15:0] d;
        host.read_reg(a, d);
        check_word(d, exp);
    endtask

    task automatic drive_prim(input int i, input logic v);
        case (i)
            4: vseq <= v;
            5: iseq <= v;
            6: dip <= v;
            7: loss <= v;
            default: cs_err[i] <= v;
        endcase
    endtask

    task automatic drive_sec(input int k, input logic [15:0] v);
        case (k)
            0: srms <= v;
            1: crms <= v;
            2: vdist[ph] <= v;
            3: idist[ph] <= v;
            default: hready <= |v;
        endcase
    endtask

    task automatic pulse_sec(input int k, input logic [15:0] v);
        @(posedge clock_i);
        drive_sec(k, v);
        @(posedge clock_i);
        drive_sec(k, 16'h0000);
        #1;
    endtask

    task automatic step(input int c, input logic fine, input logic rev);
        @(posedge clock_i);
        if (fine) sfine[c] <= 1'b1;
        else scoarse[c] <= 1'b1;
        srev[c] <= rev;
        @(posedge clock_i);
        sfine   <= 8'h00;
        scoarse <= 8'h00;
        #1;
    endtask

    initial begin
        repeat (60000) @(posedge clock_i);
        failures++;
        $display("mismatch at %0t: run did not finish", $time);
        print_verdict();
    end

    initial begin
        repeat (10) @(posedge clock_i);
        arst_n_i <= 1'b1;
        foreach (raddr[j]) rd_check(raddr[j], rrst[j]);
        host.write_reg(STATUS_PRIMARY_ADDR, 16'hFFFF, STATUS_PRIMARY_MASK);
        rd_check(STATUS_PRIMARY_ADDR, 16'h0000);
        for (int j = 0; j < 4; j++) begin
            en = 16'($random(seed));
            host.write_reg(ENABLE_PRIMARY_ADDR, en, ENABLE_PRIMARY_MASK);
            rd_check(ENABLE_PRIMARY_ADDR, en & 16'h04CC);
            host.write_reg(ENABLE_SECONDARY_ADDR, ~en, SECONDARY_MASK);
            rd_check(ENABLE_SECONDARY_ADDR, ~en & 16'hCEFF);
        end
        $display("test registers done");
        for (int i = 0; i < 8; i++) begin
            en = 16'($random(seed)) & 16'h04CC;
            host.write_reg(ENABLE_PRIMARY_ADDR, en, ENABLE_PRIMARY_MASK);
            @(posedge clock_i);
            drive_prim(i, 1'b1);
            @(posedge clock_i);
            drive_prim(i, 1'b0);
            tick();
            check_pin(pin1, en[pbit[i]]);
            check_pin(warn, logic'(i < 4));
            rd_check(STATUS_PRIMARY_ADDR, onehot(pbit[i]));
            rd_check(STATUS_PRIMARY_ADDR, 16'h0000);
            tick();
            check_pin(pin1, 1'b0);
            check_pin(warn, 1'b0);
        end
        $display("test primary events done");
        for (int k = 0; k < 5; k++) begin
            en = 16'($random(seed)) & 16'hCEFF;
            host.write_reg(ENABLE_SECONDARY_ADDR, en, SECONDARY_MASK);
            lim = 16'($random(seed)) & 16'h7FFF;
            ph = {$random(seed)} % 3;
            if (k < 4) begin
                host.write_reg(larr[k], lim, 16'hFFFF);
                pulse_sec(k, lim);
                rd_check(STATUS_SECONDARY_ADDR, 16'h0000);
            end
            pulse_sec(k, lim + 16'h0001);
            tick();
            check_pin(pin2, en[sbit[k]]);
            rd_check(STATUS_SECONDARY_ADDR, onehot(sbit[k]));
            tick();
            check_pin(pin2, 1'b0);
        end
        $display("test secondary events done");
        for (int c = 0; c < 8; c++) begin
            host.write_reg(ENABLE_SECONDARY_ADDR, onehot(c), SECONDARY_MASK);
            rsel <= c[0];
            step(c, c[0], 1'b0);
            step(c, !c[0], 1'b1);
            rd_check(STATUS_SECONDARY_ADDR, 16'h0000);
            step(c, c[0], 1'b1);
            tick();
            check_pin(pin2, 1'b1);
            rd_check(STATUS_SECONDARY_ADDR, onehot(c));
        end
        $display("test reversals done");
        host.write_reg(ENABLE_PRIMARY_ADDR, 16'h0008, ENABLE_PRIMARY_MASK);
        dip <= 1'b1;
        loss <= 1'b1;
        tick();
        tick();
        check_pin(pin1, 1'b1);
        rd_check(STATUS_PRIMARY_ADDR, 16'h000C);
        rd_check(STATUS_PRIMARY_ADDR, 16'h000C);
        @(posedge clock_i);
        dip <= 1'b0;
        loss <= 1'b0;
        rd_check(STATUS_PRIMARY_ADDR, 16'h000C);
        rd_check(STATUS_PRIMARY_ADDR, 16'h0000);
        tick();
        check_pin(pin1, 1'b0);
        $display("test set over clear done");
        @(posedge clock_i);
        cs_err[0] <= 1'b1;
        dip       <= 1'b1;
        @(posedge clock_i);
        arst_n_i  <= 1'b0;
        cs_err    <= 4'h0;
        dip       <= 1'b0;
        tick();
        check_pin(warn, 1'b0);
        check_pin(pin1, 1'b0);
        repeat (10) @(posedge clock_i);
        arst_n_i <= 1'b1;
        rd_check(STATUS_PRIMARY_ADDR, 16'h0000);
        rd_check(ENABLE_PRIMARY_ADDR, 16'h0000);
        rd_check(SAMPLED_LIMIT_ADDR, 16'hFFFF);
        $display("test second reset done");
        print_verdict();
    end
endmodule
`default_nettype wire
